// ==== verilog/gpp_consts.svh ====
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH

`define GPP_NPINS          16
`define GPP_RST_WORD       16'h0000

// register word offsets on the plain register port
`define GPP_OFF_PULL_EN    8'h00
`define GPP_OFF_DATA       8'h01
`define GPP_OFF_DIR        8'h02
`define GPP_OFF_PERIPH     8'h03
`define GPP_OFF_SW_IRQ     8'h04
`define GPP_OFF_IRQ_EN     8'h05
`define GPP_OFF_IRQ_POL    8'h06
`define GPP_OFF_PENDING    8'h07
`define GPP_OFF_EDGE       8'h08
`define GPP_OFF_PUSH_PULL  8'h09
`define GPP_OFF_RAW        8'h0A
`define GPP_OFF_DRIVE      8'h0B
`define GPP_OFF_PULL_UP    8'h0C
`define GPP_OFF_FILT_EN    8'h0D
`define GPP_OFF_SLEW       8'h0E
`define GPP_OFF_EDGE_CLR   8'h0F
`define GPP_OFF_DATA_SET   8'h10
`define GPP_OFF_DATA_CLR   8'h11
`define GPP_OFF_DATA_TGL   8'h12
`define GPP_OFF_ASSIGN_PER 8'h13
`define GPP_OFF_MAKE_OUT   8'h14
`define GPP_OFF_FORCE_SW   8'h15
`define GPP_OFF_SEL_OD     8'h16
`define GPP_OFF_SEL_PP     8'h17

// input filter: a level must stay stable this long to pass
`define GPP_CLK_PERIOD_NS  25
`define GPP_FILT_TIME_NS   100
`define GPP_FILT_CYC       ((`GPP_FILT_TIME_NS + `GPP_CLK_PERIOD_NS - 1) / `GPP_CLK_PERIOD_NS)
`define GPP_FILT_CW        3

`endif

// ==== verilog/gpp_pkg.sv ====
package gpp_pkg;
  typedef logic [15:0] gpp_pins_t;
  typedef logic [7:0]  gpp_addr_t;
  typedef enum logic [0:0] {
    GPP_FILT_STABLE = 1'b0,
    GPP_FILT_COUNT  = 1'b1
  } gpp_filt_state_t;
endpackage

// ==== verilog/gpp_pin_cond.sv ====
`timescale 1ns/1ps
`include "gpp_consts.svh"

module gpp_pin_cond
  import gpp_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic pad_i,
  input  wire logic filt_en_i,
  output logic      cond_o
);
  logic                    sync1_q;
  logic                    sync2_q;
  logic                    cond_q;
  logic [`GPP_FILT_CW-1:0] cnt_q;
  gpp_filt_state_t         state_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pad_i;
      sync2_q <= sync1_q;
    end
  end

  // with the filter enabled, a change passes only after it stayed put for the full filter time; disabled, it passes at once
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= GPP_FILT_STABLE;
      cnt_q   <= '0;
      cond_q  <= 1'b0;
    end else if (!filt_en_i) begin // see R14
      state_q <= GPP_FILT_STABLE;
      cnt_q   <= '0;
      cond_q  <= sync2_q;
    end else begin
      case (state_q)
        GPP_FILT_STABLE: begin
          cnt_q <= '0;
          if (sync2_q != cond_q) begin
            state_q <= GPP_FILT_COUNT;
          end
        end
        GPP_FILT_COUNT: begin
          if (sync2_q == cond_q) begin
            state_q <= GPP_FILT_STABLE;
          end else if (cnt_q == `GPP_FILT_CW'(`GPP_FILT_CYC - 1)) begin // see R14
            cond_q  <= sync2_q;
            state_q <= GPP_FILT_STABLE;
          end else begin
            cnt_q <= cnt_q + `GPP_FILT_CW'(1);
          end
        end
        default: begin
          state_q <= GPP_FILT_STABLE;
        end
      endcase
    end
  end

  assign cond_o = cond_q;
endmodule // gpp_pin_cond

// ==== verilog/gpp_irq_cell.sv ====
`timescale 1ns/1ps

module gpp_irq_cell
  import gpp_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic cond_i,
  input  wire logic pol_i,
  input  wire logic en_i,
  input  wire logic sw_i,
  input  wire logic clr_i,
  output logic      edge_o,
  output logic      pend_o
);
  logic sense;
  logic sense_q;
  logic edge_q;

  // polarity set means the low level is the active sense
  assign sense = cond_i ^ pol_i; // see R7

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sense_q <= 1'b0;
    end else begin
      sense_q <= sense;
    end
  end

  // new edge wins over a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      edge_q <= 1'b0;
    end else begin
      edge_q <= (sense & ~sense_q) | (edge_q & ~clr_i); // see R10, R17
    end
  end

  assign edge_o = edge_q;
  assign pend_o = (edge_q | sw_i) & en_i; // see R8, R11, R17
endmodule // gpp_irq_cell

// ==== verilog/gpp_port.sv ====
// Notes on behaviour
// R1: up to sixteen pins, bit n of every control register steers pin n.
// R2: software reads and writes pin values, or uses pins as interrupt sources.
// R3: peripheral-enable bit hands pin to its peripheral; clear means port control.
// R4: direction bit set drives pin as output, clear makes it input.
// R5: data register read/write as word; sets levels of port-owned outputs.
// R6: raw data register returns every pin level, peripheral pins included.
// R7: polarity bit picks high or low active sense for interrupt detection.
// R8: interrupt enable bit gates each pin's request; clear suppresses it.
// R9: pending register shows one outstanding request flag per pin.
// R10: edge flags latch detected edges; write one clears, zero keeps.
// R11: software assert bit raises a pin request while set.
// R12: push-pull bit set drives both levels; clear gives open drain, low only.
// R13: per-pin pull resistor enable and pull-up versus pull-down select.
// R14: filter enable inserts low-pass filter on input, else bypassed.
// R15: drive strength bit set picks high-strength driver, clear low-strength.
// R16: slew bit set enables slew-rate-limited output mode.
// R17: edge flag sets on change into active sense; pending is masked OR.
// R18: single interrupt output high while any pending flag is set.
`timescale 1ns/1ps
`include "gpp_consts.svh"

module gpp_port
  import gpp_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      srst_i,
  input  wire gpp_addr_t addr_i,
  input  wire gpp_pins_t wdata_i,
  input  wire logic      wr_i,
  input  wire logic      rd_i,
  output gpp_pins_t      rdata_o,
  input  wire gpp_pins_t pad_in_i,
  output gpp_pins_t      pad_out_o,
  output gpp_pins_t      pad_oe_n_o,
  output gpp_pins_t      pull_en_o,
  output gpp_pins_t      pull_up_o,
  output gpp_pins_t      drive_high_o,
  output gpp_pins_t      slew_limit_o,
  input  wire gpp_pins_t periph_out_i,
  input  wire gpp_pins_t periph_oe_i,
  output gpp_pins_t      periph_in_o,
  output logic           irq_o
);
  gpp_pins_t pull_en_q;
  gpp_pins_t pull_up_q;
  gpp_pins_t data_q;
  gpp_pins_t dir_q;
  gpp_pins_t periph_en_q;
  gpp_pins_t sw_irq_q;
  gpp_pins_t irq_en_q;
  gpp_pins_t irq_pol_q;
  gpp_pins_t push_pull_q;
  gpp_pins_t drive_q;
  gpp_pins_t filt_en_q;
  gpp_pins_t slew_q;
  gpp_pins_t pending_q;
  gpp_pins_t rdata_q;
  gpp_pins_t rdata_d;
  gpp_pins_t pad_out_q;
  gpp_pins_t pad_out_d;
  gpp_pins_t pad_oe_n_q;
  gpp_pins_t pad_oe_n_d;
  gpp_pins_t periph_in_q;
  logic      irq_q;

  gpp_pins_t cond;
  gpp_pins_t edge_flags;
  gpp_pins_t pend;
  gpp_pins_t edge_clr;

  // write strobes decoded once
  logic wr_pull_en;
  logic wr_pull_up;
  logic wr_data;
  logic wr_dir;
  logic wr_periph;
  logic wr_sw_irq;
  logic wr_irq_en;
  logic wr_irq_pol;
  logic wr_push_pull;
  logic wr_drive;
  logic wr_filt_en;
  logic wr_slew;
  logic wr_edge;
  logic wr_data_set;
  logic wr_data_clr;
  logic wr_data_tgl;
  logic assign_pin_to_peripheral_cmd;
  logic make_pin_output_cmd;
  logic force_software_irq_cmd;
  logic select_open_drain_cmd;
  logic select_push_pull_cmd;

  assign wr_pull_en   = wr_i && (addr_i == `GPP_OFF_PULL_EN);
  assign wr_pull_up   = wr_i && (addr_i == `GPP_OFF_PULL_UP);
  assign wr_data      = wr_i && (addr_i == `GPP_OFF_DATA);
  assign wr_dir       = wr_i && (addr_i == `GPP_OFF_DIR);
  assign wr_periph    = wr_i && (addr_i == `GPP_OFF_PERIPH);
  assign wr_sw_irq    = wr_i && (addr_i == `GPP_OFF_SW_IRQ);
  assign wr_irq_en    = wr_i && (addr_i == `GPP_OFF_IRQ_EN);
  assign wr_irq_pol   = wr_i && (addr_i == `GPP_OFF_IRQ_POL);
  assign wr_push_pull = wr_i && (addr_i == `GPP_OFF_PUSH_PULL);
  assign wr_drive     = wr_i && (addr_i == `GPP_OFF_DRIVE);
  assign wr_filt_en   = wr_i && (addr_i == `GPP_OFF_FILT_EN);
  assign wr_slew      = wr_i && (addr_i == `GPP_OFF_SLEW);
  // both the flag word itself and its clear alias take write-one-to-clear
  assign wr_edge      = wr_i && ((addr_i == `GPP_OFF_EDGE) || (addr_i == `GPP_OFF_EDGE_CLR));
  assign wr_data_set  = wr_i && (addr_i == `GPP_OFF_DATA_SET);
  assign wr_data_clr  = wr_i && (addr_i == `GPP_OFF_DATA_CLR);
  assign wr_data_tgl  = wr_i && (addr_i == `GPP_OFF_DATA_TGL);
  assign assign_pin_to_peripheral_cmd = wr_i && (addr_i == `GPP_OFF_ASSIGN_PER);
  assign make_pin_output_cmd          = wr_i && (addr_i == `GPP_OFF_MAKE_OUT);
  assign force_software_irq_cmd       = wr_i && (addr_i == `GPP_OFF_FORCE_SW);
  assign select_open_drain_cmd        = wr_i && (addr_i == `GPP_OFF_SEL_OD);
  assign select_push_pull_cmd         = wr_i && (addr_i == `GPP_OFF_SEL_PP);

  assign edge_clr = wr_edge ? wdata_i : `GPP_RST_WORD; // see R10

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pull_en_q <= `GPP_RST_WORD;
    end else if (wr_pull_en) begin
      pull_en_q <= wdata_i; // see R13
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pull_up_q <= `GPP_RST_WORD;
    end else if (wr_pull_up) begin
      pull_up_q <= wdata_i; // see R13
    end
  end

  // set, clear and toggle aliases save software a read-modify-write
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      data_q <= `GPP_RST_WORD;
    end else if (wr_data) begin
      data_q <= wdata_i; // see R5
    end else if (wr_data_set) begin
      data_q <= data_q | wdata_i;
    end else if (wr_data_clr) begin
      data_q <= data_q & ~wdata_i;
    end else if (wr_data_tgl) begin
      data_q <= data_q ^ wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dir_q <= `GPP_RST_WORD;
    end else if (wr_dir) begin
      dir_q <= wdata_i; // see R4
    end else if (make_pin_output_cmd) begin
      dir_q <= dir_q | wdata_i; // see R4
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      periph_en_q <= `GPP_RST_WORD;
    end else if (wr_periph) begin
      periph_en_q <= wdata_i; // see R3
    end else if (assign_pin_to_peripheral_cmd) begin
      periph_en_q <= periph_en_q | wdata_i; // see R3
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sw_irq_q <= `GPP_RST_WORD;
    end else if (wr_sw_irq) begin
      sw_irq_q <= wdata_i; // see R11
    end else if (force_software_irq_cmd) begin
      sw_irq_q <= sw_irq_q | wdata_i; // see R11
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_en_q <= `GPP_RST_WORD;
    end else if (wr_irq_en) begin
      irq_en_q <= wdata_i; // see R8
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_pol_q <= `GPP_RST_WORD;
    end else if (wr_irq_pol) begin
      irq_pol_q <= wdata_i; // see R7
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      push_pull_q <= `GPP_RST_WORD;
    end else if (wr_push_pull) begin
      push_pull_q <= wdata_i; // see R12
    end else if (select_push_pull_cmd) begin
      push_pull_q <= push_pull_q | wdata_i; // see R12
    end else if (select_open_drain_cmd) begin
      push_pull_q <= push_pull_q & ~wdata_i; // see R12
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      drive_q <= `GPP_RST_WORD;
    end else if (wr_drive) begin
      drive_q <= wdata_i; // see R15
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      filt_en_q <= `GPP_RST_WORD;
    end else if (wr_filt_en) begin
      filt_en_q <= wdata_i; // see R14
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      slew_q <= `GPP_RST_WORD;
    end else if (wr_slew) begin
      slew_q <= wdata_i; // see R16
    end
  end

  // per-pin input conditioning and interrupt detection
  genvar gi;
  generate
    for (gi = 0; gi < `GPP_NPINS; gi++) begin : g_pin // see R1
      gpp_pin_cond u_cond (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .pad_i      (pad_in_i[gi]),
        .filt_en_i  (filt_en_q[gi]),
        .cond_o     (cond[gi])
      );
      gpp_irq_cell u_irq (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .cond_i     (cond[gi]),
        .pol_i      (irq_pol_q[gi]),
        .en_i       (irq_en_q[gi]),
        .sw_i       (sw_irq_q[gi]),
        .clr_i      (edge_clr[gi]),
        .edge_o     (edge_flags[gi]),
        .pend_o     (pend[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pending_q <= `GPP_RST_WORD;
    end else begin
      pending_q <= pend; // see R9
    end
  end

  // level output, registered in the same cycle as the pending word
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |pend; // see R18
    end
  end

  // peripheral sees the conditioned level whoever owns the pin
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      periph_in_q <= `GPP_RST_WORD;
    end else begin
      periph_in_q <= cond;
    end
  end

  // open drain only ever drives low; a high is left to the pull or the board
  always_comb begin
    pad_out_d  = `GPP_RST_WORD;
    pad_oe_n_d = ~`GPP_RST_WORD;
    for (int i = 0; i < `GPP_NPINS; i++) begin
      logic lvl;
      logic drv;
      lvl = 1'b0;
      drv = 1'b0;
      if (periph_en_q[i]) begin // see R3
        lvl = periph_out_i[i];
        drv = periph_oe_i[i];
      end else begin
        lvl = data_q[i]; // see R5
        drv = dir_q[i]; // see R4
      end
      if (push_pull_q[i]) begin // see R12
        pad_out_d[i]  = lvl;
        pad_oe_n_d[i] = ~drv;
      end else begin
        pad_out_d[i]  = 1'b0;
        pad_oe_n_d[i] = ~(drv & ~lvl);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pad_out_q  <= `GPP_RST_WORD;
      pad_oe_n_q <= ~`GPP_RST_WORD;
    end else begin
      pad_out_q  <= pad_out_d;
      pad_oe_n_q <= pad_oe_n_d;
    end
  end

  // read mux; aliases and unmapped offsets read zero
  always_comb begin
    rdata_d = `GPP_RST_WORD;
    case (addr_i)
      `GPP_OFF_PULL_EN:   rdata_d = pull_en_q;
      `GPP_OFF_PULL_UP:   rdata_d = pull_up_q;
      `GPP_OFF_DATA:      rdata_d = data_q; // see R2, R5
      `GPP_OFF_DIR:       rdata_d = dir_q;
      `GPP_OFF_PERIPH:    rdata_d = periph_en_q;
      `GPP_OFF_SW_IRQ:    rdata_d = sw_irq_q;
      `GPP_OFF_IRQ_EN:    rdata_d = irq_en_q;
      `GPP_OFF_IRQ_POL:   rdata_d = irq_pol_q;
      `GPP_OFF_PENDING:   rdata_d = pending_q; // see R9
      `GPP_OFF_EDGE:      rdata_d = edge_flags; // see R10
      `GPP_OFF_PUSH_PULL: rdata_d = push_pull_q;
      `GPP_OFF_RAW:       rdata_d = cond; // see R2, R6
      `GPP_OFF_DRIVE:     rdata_d = drive_q;
      `GPP_OFF_FILT_EN:   rdata_d = filt_en_q;
      `GPP_OFF_SLEW:      rdata_d = slew_q;
      default:            rdata_d = `GPP_RST_WORD;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_q <= `GPP_RST_WORD;
    end else if (rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `GPP_RST_WORD;
    end
  end

  assign rdata_o      = rdata_q;
  assign pad_out_o    = pad_out_q;
  assign pad_oe_n_o   = pad_oe_n_q;
  assign pull_en_o    = pull_en_q; // see R13
  assign pull_up_o    = pull_up_q; // see R13
  assign drive_high_o = drive_q; // see R15
  assign slew_limit_o = slew_q; // see R16
  assign periph_in_o  = periph_in_q;
  assign irq_o        = irq_q; // see R18
endmodule // gpp_port

// ==== tb/gpp_pad_model.sv ====
`timescale 1ns/1ps

module gpp_pad_model
  import gpp_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire gpp_pins_t pad_out_i,
  input  wire gpp_pins_t pad_oe_n_i,
  input  wire gpp_pins_t pull_en_i,
  input  wire gpp_pins_t pull_up_i,
  input  wire gpp_pins_t ext_val_i,
  input  wire gpp_pins_t ext_en_i,
  output gpp_pins_t      pad_o
);
  // an undriven, unpulled pin wanders instead of holding its last level
  gpp_pins_t float_q = 16'h5555;

  always_ff @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end

  // wired resolution: any low driver wins, as on a real shared pin
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pad_oe_n_i[i] || ext_en_i[i]) begin
        pad_o[i] = (pad_oe_n_i[i] | pad_out_i[i]) & (!ext_en_i[i] | ext_val_i[i]);
      end else begin
        pad_o[i] = pull_en_i[i] ? pull_up_i[i] : float_q[i];
      end
    end
  end
endmodule // gpp_pad_model

// ==== tb/gpp_port_assertions.sv ====
`timescale 1ns/1ps

module gpp_port_assertions
  import gpp_pkg::*;
(
  input wire logic      core_clk_i,
  input wire logic      srst_i,
  input wire gpp_addr_t addr_i,
  input wire gpp_pins_t wdata_i,
  input wire logic      wr_i,
  input wire logic      rd_i,
  input wire gpp_pins_t rdata_o,
  input wire gpp_pins_t pull_en_o,
  input wire gpp_pins_t drive_high_o,
  input wire gpp_pins_t slew_limit_o,
  input wire logic      irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_wr(logic [7:0] a);
    wr_i && addr_i == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence
  // a second write to the same word would legally move the output again
  property p_mirror(logic [7:0] a, gpp_pins_t q);
    s_wr(a) ##1 !(wr_i && addr_i == a) |=> q == $past(wdata_i, 2);
  endproperty

  a_pull_en_mirror: assert property (p_mirror(8'h00, pull_en_o))
    else $error("pull enable output differs from write");
  a_drive_mirror: assert property (p_mirror(8'h0B, drive_high_o))
    else $error("drive output differs from write");
  a_slew_mirror: assert property (p_mirror(8'h0E, slew_limit_o))
    else $error("slew output differs from write");
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data present without a read");
  a_data_read_back: assert property (s_wr(8'h01) ##1 s_rd(8'h01)
    |=> rdata_o == $past(wdata_i, 2)) else $error("data read back differs");
  a_edge_w1c: assert property (s_wr(8'h08) ##1 s_rd(8'h08)
    |=> (rdata_o & $past(wdata_i, 2)) == 16'h0000) else $error("edge flag kept");
  a_wo_read_zero: assert property (rd_i && addr_i >= 8'h0F |=> rdata_o == 16'h0000)
    else $error("write-only word read nonzero");
  a_pend_masked: assert property (s_wr(8'h05) ##1 !wr_i ##1 s_rd(8'h07)
    |=> (rdata_o & ~$past(wdata_i, 3)) == 16'h0000) else $error("masked pin pending");
  a_irq_any_pend: assert property (s_rd(8'h07) |=> (|rdata_o) == $past(irq_o))
    else $error("irq disagrees with pending word");
endmodule // gpp_port_assertions

bind gpp_port gpp_port_assertions gpp_port_assertions_i (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pull_en_o(pull_en_o),
  .drive_high_o(drive_high_o), .slew_limit_o(slew_limit_o), .irq_o(irq_o)
);

// ==== tb/tb.sv ====
`timescale 1ns/1ps

module tb
  import gpp_pkg::*;
;
  logic      core_clk_i, srst_i, wr_i, rd_i, irq_o;
  gpp_addr_t addr_i;
  gpp_pins_t wdata_i, rdata_o, pad_in_i, pad_out_o, pad_oe_n_o, pull_en_o, pull_up_o;
  gpp_pins_t drive_high_o, slew_limit_o, periph_out_i, periph_oe_i, periph_in_o;
  gpp_pins_t ext_val, ext_en, rv;
  int        miscompares, n_checks;

  gpp_port gpp_port_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pull_en_o(pull_en_o),
    .pull_up_o(pull_up_o), .drive_high_o(drive_high_o), .slew_limit_o(slew_limit_o),
    .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o),
    .irq_o(irq_o)
  );
  gpp_pad_model pad_model_i (
    .core_clk_i(core_clk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
    .pull_en_i(pull_en_o), .pull_up_i(pull_up_o), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .pad_o(pad_in_i)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input gpp_pins_t e, input gpp_pins_t g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic irq_is(input logic e);
    chk("irq", {15'h0000, e}, {15'h0000, irq_o});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic bus(input logic w, input gpp_addr_t a, input gpp_pins_t d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic rdc(input gpp_addr_t a, input gpp_pins_t e);
    bus(1'b0, a, 16'h0000);
    chk($sformatf("word %h", a), e, rv);
  endtask
  // write and read of one word on adjacent cycles
  task automatic wr_rd(input gpp_addr_t a, input gpp_pins_t d, input gpp_pins_t e);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk("read back", e, rdata_o);
  endtask
  task automatic pin(input gpp_pins_t v, input int n);
    @(posedge core_clk_i);
    ext_val <= v;
    cyc(n);
  endtask

  task automatic t_reset();
    chk("oe_n", 16'hFFFF, pad_oe_n_o);
    irq_is(1'b0);
    for (int a = 0; a < 16; a++) begin
      rdc(gpp_addr_t'(a), 16'h0000);
    end
    bus(1'b1, 8'h20, 16'hFFFF);
    rdc(8'h20, 16'h0000);
  endtask
  task automatic t_gpio();
    @(posedge core_clk_i);
    ext_en <= 16'h0000;
    bus(1'b1, 8'h00, 16'hFFFF);
    bus(1'b1, 8'h0C, 16'hFFFF);
    bus(1'b1, 8'h14, 16'hFFFF);
    bus(1'b1, 8'h17, 16'hFFFF);
    wr_rd(8'h01, 16'hA5C3, 16'hA5C3);
    cyc(2);
    chk("pad_out", 16'hA5C3, pad_out_o);
    chk("oe_n", 16'h0000, pad_oe_n_o);
    bus(1'b1, 8'h10, 16'h0A00);
    rdc(8'h01, 16'hAFC3);
    bus(1'b1, 8'h11, 16'h0F00);
    bus(1'b1, 8'h12, 16'h0500);
    rdc(8'h01, 16'hA5C3);
    bus(1'b1, 8'h16, 16'hFFFF);
    cyc(6);
    chk("od pad_out", 16'h0000, pad_out_o);
    chk("od oe_n", 16'hA5C3, pad_oe_n_o);
    rdc(8'h0A, 16'hA5C3);
    chk("pull_en", 16'hFFFF, pull_en_o);
    chk("pull_up", 16'hFFFF, pull_up_o);
    bus(1'b1, 8'h0C, 16'h0000);
    cyc(6);
    rdc(8'h0A, 16'h0000);
    chk("pull_down", 16'h0000, pull_up_o);
    rdc(8'h09, 16'h0000);
    bus(1'b1, 8'h02, 16'h0000);
    bus(1'b1, 8'h0B, 16'h1234);
    bus(1'b1, 8'h0E, 16'h4321);
    cyc(2);
    chk("oe_n in", 16'hFFFF, pad_oe_n_o);
    chk("drive", 16'h1234, drive_high_o);
    chk("slew", 16'h4321, slew_limit_o);
  endtask
  task automatic t_periph();
    @(posedge core_clk_i);
    periph_out_i <= 16'h3C3C;
    periph_oe_i <= 16'hFFFF;
    bus(1'b1, 8'h13, 16'hFFFF);
    bus(1'b1, 8'h17, 16'hFFFF);
    cyc(6);
    chk("per pad_out", 16'h3C3C, pad_out_o);
    chk("per oe_n", 16'h0000, pad_oe_n_o);
    chk("per in", 16'h3C3C, periph_in_o);
    rdc(8'h0A, 16'h3C3C);
    bus(1'b1, 8'h03, 16'h0000);
    cyc(2);
    chk("port oe_n", 16'hFFFF, pad_oe_n_o);
    @(posedge core_clk_i);
    ext_en <= 16'hFFFF;
    periph_oe_i <= 16'h0000;
  endtask
  task automatic t_filter(input logic on, input logic e);
    logic seen;
    seen = 1'b0;
    bus(1'b1, 8'h0D, {15'h0000, on});
    pin(16'h0001, 2);
    pin(16'h0000, 0);
    repeat (12) begin
      @(posedge core_clk_i);
      #1 seen = seen | periph_in_o[0];
    end
    chk("short pulse", {15'h0000, e}, {15'h0000, seen});
    // a level held well past the filter time must get through either way
    pin(16'h0001, 10);
    chk("long pulse", 16'h0001, periph_in_o);
    pin(16'h0000, 10);
    chk("long low", 16'h0000, periph_in_o);
    bus(1'b1, 8'h0D, 16'h0000);
  endtask
  task automatic t_irq();
    bus(1'b1, 8'h0F, 16'hFFFF);
    bus(1'b1, 8'h05, 16'h0003);
    pin(16'h0001, 8);
    irq_is(1'b1);
    rdc(8'h07, 16'h0001);
    pin(16'h0000, 8);
    bus(1'b1, 8'h08, 16'h0000);
    rdc(8'h08, 16'h0001);
    bus(1'b1, 8'h0F, 16'h0001);
    cyc(2);
    irq_is(1'b0);
    // pin 1 sits low, so flipping its sense counts as an arrival
    bus(1'b1, 8'h06, 16'h0002);
    cyc(3);
    irq_is(1'b1);
    wr_rd(8'h08, 16'h0002, 16'h0000);
    cyc(2);
    irq_is(1'b0);
    pin(16'h0004, 8);
    irq_is(1'b0);
    rdc(8'h08, 16'h0004);
    bus(1'b1, 8'h05, 16'h0004);
    rdc(8'h07, 16'h0004);
    bus(1'b1, 8'h0F, 16'h0004);
    bus(1'b1, 8'h05, 16'h0008);
    bus(1'b1, 8'h15, 16'h0008);
    cyc(2);
    irq_is(1'b1);
    rdc(8'h04, 16'h0008);
    bus(1'b1, 8'h04, 16'h0000);
    cyc(2);
    irq_is(1'b0);
    bus(1'b1, 8'h07, 16'hFFFF);
    rdc(8'h07, 16'h0000);
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    periph_out_i = 16'h0000;
    periph_oe_i = 16'h0000;
    ext_val = 16'h0000;
    ext_en = 16'hFFFF;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge core_clk_i);
    srst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_gpio();
    t_periph();
    t_filter(1'b0, 1'b1);
    t_filter(1'b1, 1'b0);
    t_irq();
    give_verdict();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk_i);
    miscompares++;
    give_verdict();
  end
endmodule // tb
